// *** src/sll_regs.vh ***
`ifndef SLL_REGS_VH
`define SLL_REGS_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SLL_CLK_MHZ 125
`define SLL_FTO_UNIT_NS 10000
// ----------------------------------------
// frame constants
// ----------------------------------------
`define SLL_CRC_INIT 8'hff
`define SLL_CRC_POLY 8'h07
`define SLL_TGT_WR 7
`define SLL_TGT_BC 6
`define SLL_TGT_LEN_HI 5
`define SLL_TGT_LEN_LO 4
`define SLL_TGT_ADDR_HI 3
// ----------------------------------------
// register groups and offsets
// ----------------------------------------
`define SLL_CUR_LO 8'h00
`define SLL_CUR_HI 8'h0b
`define SLL_DUTY_LO 8'h20
`define SLL_DUTY_HI 8'h2b
`define SLL_LDUTY_LO 8'h30
`define SLL_LDUTY_HI 8'h3b
`define SLL_CONF_LO 8'h50
`define SLL_CONF_HI 8'h5b
`define SLL_CLR_LO 8'h60
`define SLL_CLR_HI 8'h6b
`define SLL_REG_LOCK 8'h70
`define SLL_REG_ADDRCFG 8'h71
`define SLL_REG_TIMEOUT 8'h72
`define SLL_REG_CHECKSUM 8'h7e
`define SLL_REG_LINKSTAT 8'h7f
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SLL_LOCK_CUR 0
`define SLL_LOCK_DIM 1
`define SLL_LOCK_CONF 2
`define SLL_LOCK_CLR 3
`define SLL_ADDRCFG_SEL 4
`define SLL_LOCK_RESET 8'h0f
`define SLL_ADDRCFG_RESET 8'h00
`define SLL_TIMEOUT_RESET 8'h0f
`endif

// *** src/sll_link_slave.v ***
// Summary of operation
// RQ1: up to sixteen slaves, four-bit addresses
// RQ2: select bit 1 uses stored address, pins repurposed
// RQ3: select bit 0 uses stored bit3 plus pins
// RQ4: host broadcasts using target address zero
// RQ5: host keeps slave addresses unique
// RQ6: good addressed frame returns flag byte, CRC
// RQ7: broadcast frames never get a response
// RQ8: sync byte sets bit timing
// RQ9: every frame re-derives timing from sync
// RQ10: target byte low nibble is slave address
// RQ11: target bits 5-4 give data length
// RQ12: bit 6 broadcast, only with address zero
// RQ13: target bit 7 set means write
// RQ14: register index byte follows target byte
// RQ15: host CRC over frame, seed FFh
// RQ16: CRC mismatch discards frame, no watchdog clear
// RQ17: burst writes go to incrementing addresses
// RQ18: burst reads come from incrementing addresses
// RQ19: four lock bits, default set, block writes
// RQ20: each lock guards its own register group
// RQ21: readable CRC over all registers, seed FFh
// RQ22: bytes are start, eight LSB-first, stop
// RQ23: idle beyond timeout abandons the frame
// RQ24: only verified frames respond, clear watchdog
// RQ25: read data precede status and CRC
// RQ26: CRC polynomial is a shared parameter
`timescale 1ns/10ps
`include "sll_regs.vh"
module sll_link_slave #(
  parameter [7:0] CRC_POLY = `SLL_CRC_POLY,
  parameter integer TO_UNIT_CYC = `SLL_FTO_UNIT_NS * `SLL_CLK_MHZ / 1000,
  parameter integer TW = 20
) (
  input wire clock,
  input wire reset_n,
  input wire rx,
  output reg tx,
  input wire addr_pin_2,
  input wire addr_pin_1,
  input wire addr_pin_0,
  input wire [7:0] primary_flag_byte,
  output reg link_watchdog_clear,
  output reg pwm_clk_out,
  output reg [1:0] pwm_direct_out,
  output reg frame_busy,
  input wire [7:0] sw_addr,
  input wire [7:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  output reg [7:0] sw_rdata
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SYNC = 3'd1;
  localparam [2:0] ST_GAP = 3'd2;
  localparam [2:0] ST_RXB = 3'd3;
  localparam [2:0] ST_WR = 3'd4;
  localparam [2:0] ST_TXLD = 3'd5;
  localparam [2:0] ST_TXB = 3'd6;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] mem [0:255];
  reg [7:0] dbuf [0:7];
  reg [2:0] state;
  reg rx_q;
  reg [TW-1:0] cnt;
  reg [TW-1:0] bit_len;
  reg [2:0] falls;
  reg [3:0] bitn;
  reg [7:0] rxb;
  reg [3:0] byte_idx;
  reg [7:0] tgt;
  reg [7:0] ridx;
  reg [7:0] crc_acc;
  reg [23:0] idle_cnt;
  reg [3:0] wk;
  reg [9:0] tx_sh;
  reg [7:0] tx_crc;
  reg [7:0] scan_ptr;
  reg [7:0] scan_crc;
  reg [7:0] checksum;
  reg last_bad;
  reg last_ok;
  integer i;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    reg [7:0] r;
    integer k;
    begin
      r = c ^ d;
      for (k = 0; k < 8; k = k + 1) begin
        if (r[7])
          r = {r[6:0], 1'b0} ^ CRC_POLY; // [RQ26]
        else
          r = {r[6:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction

  function in_rng;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  function wr_ok;
    input [7:0] a;
    input [7:0] lk;
    begin
      wr_ok = !((in_rng(a, `SLL_CUR_LO, `SLL_CUR_HI) && lk[`SLL_LOCK_CUR])
        || ((in_rng(a, `SLL_DUTY_LO, `SLL_DUTY_HI)
        || in_rng(a, `SLL_LDUTY_LO, `SLL_LDUTY_HI)) && lk[`SLL_LOCK_DIM])
        || (in_rng(a, `SLL_CONF_LO, `SLL_CONF_HI) && lk[`SLL_LOCK_CONF])
        || (in_rng(a, `SLL_CLR_LO, `SLL_CLR_HI) && lk[`SLL_LOCK_CLR]));
    end
  endfunction

  function [7:0] rd_val;
    input [7:0] a;
    begin
      if (a == `SLL_REG_CHECKSUM)
        rd_val = checksum; // [RQ21]
      else if (a == `SLL_REG_LINKSTAT)
        rd_val = {5'h00, frame_busy, last_bad, last_ok};
      else
        rd_val = mem[a];
    end
  endfunction

  // ----------------------------------------
  // decoded values
  // ----------------------------------------
  wire [7:0] addrcfg = mem[`SLL_REG_ADDRCFG];
  wire sel_int = addrcfg[`SLL_ADDRCFG_SEL];
  wire [3:0] own_addr = sel_int ? addrcfg[3:0] : // [RQ2]
    {addrcfg[3], addr_pin_2, addr_pin_1, addr_pin_0}; // [RQ3]
  wire [3:0] tgt_addr = tgt[`SLL_TGT_ADDR_HI:0]; // [RQ10] [RQ1]
  wire is_wr = tgt[`SLL_TGT_WR]; // [RQ13]
  wire is_bc = tgt[`SLL_TGT_BC] && (tgt_addr == 4'h0); // [RQ12]
  wire hit = is_bc || (tgt_addr == own_addr);
  wire [3:0] ndata = 4'd1 << tgt[`SLL_TGT_LEN_HI:`SLL_TGT_LEN_LO]; // [RQ11]
  wire [3:0] ntx = is_wr ? 4'd2 : ndata + 4'd2;
  wire [3:0] didx = byte_idx - 4'd2;
  wire [23:0] tmo_cyc = ({16'h0000, mem[`SLL_REG_TIMEOUT]} + 24'd1)
    * TO_UNIT_CYC[23:0];
  wire rx_fall = rx_q && !rx;
  wire [7:0] wr_addr = ridx + {4'h0, wk}; // [RQ17]
  wire [7:0] tx_cur = (!is_wr && wk < ndata) ? rd_val(wr_addr) : // [RQ18]
    (wk == ntx - 4'd2) ? primary_flag_byte : tx_crc; // [RQ25] [RQ6]
  wire rx_phase = (state == ST_SYNC) || (state == ST_GAP)
    || (state == ST_RXB);

  // ----------------------------------------
  // frame engine and registers
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      for (i = 0; i < 256; i = i + 1)
        mem[i] <= 8'h00;
      mem[`SLL_REG_LOCK] <= `SLL_LOCK_RESET; // [RQ19]
      mem[`SLL_REG_ADDRCFG] <= `SLL_ADDRCFG_RESET;
      mem[`SLL_REG_TIMEOUT] <= `SLL_TIMEOUT_RESET;
      for (i = 0; i < 8; i = i + 1)
        dbuf[i] <= 8'h00;
      state <= ST_IDLE;
      rx_q <= 1'b1;
      cnt <= {TW{1'b0}};
      bit_len <= {TW{1'b0}};
      falls <= 3'd0;
      bitn <= 4'd0;
      rxb <= 8'h00;
      byte_idx <= 4'd0;
      tgt <= 8'h00;
      ridx <= 8'h00;
      crc_acc <= `SLL_CRC_INIT;
      idle_cnt <= 24'h000000;
      wk <= 4'd0;
      tx_sh <= 10'h3ff;
      tx_crc <= `SLL_CRC_INIT;
      tx <= 1'b1;
      link_watchdog_clear <= 1'b0;
      last_bad <= 1'b0;
      last_ok <= 1'b0;
      frame_busy <= 1'b0;
      sw_rdata <= 8'h00;
    end else begin
      rx_q <= rx;
      link_watchdog_clear <= 1'b0;
      frame_busy <= (state != ST_IDLE);
      sw_rdata <= sw_rd ? rd_val(sw_addr) : 8'h00;
      if (sw_wr && wr_ok(sw_addr, mem[`SLL_REG_LOCK])) // [RQ20]
        mem[sw_addr] <= sw_wdata;
      if (!rx_phase || rx != rx_q)
        idle_cnt <= 24'h000000;
      else
        idle_cnt <= idle_cnt + 24'd1;
      if (rx_phase && idle_cnt >= tmo_cyc) begin
        state <= ST_IDLE; // [RQ23]
      end else begin
        case (state)
          ST_IDLE: begin
            if (rx_fall) begin
              state <= ST_SYNC; // [RQ9]
              cnt <= {TW{1'b0}};
              falls <= 3'd0;
              byte_idx <= 4'd0;
              crc_acc <= `SLL_CRC_INIT;
            end
          end
          ST_SYNC: begin
            cnt <= cnt + 1'b1;
            if (rx_fall) begin
              falls <= falls + 3'd1;
              if (falls == 3'd3) begin
                // eight bit periods between first and fifth fall
                bit_len <= (cnt + 1'b1) >> 3; // [RQ8]
                state <= ((cnt >> 4) == 0) ? ST_IDLE : ST_GAP;
              end
            end
          end
          ST_GAP: begin
            if (rx_fall) begin
              state <= ST_RXB;
              cnt <= bit_len >> 1;
              bitn <= 4'd0;
            end
          end
          ST_RXB: begin
            if (cnt != 0) begin
              cnt <= cnt - 1'b1;
            end else begin
              cnt <= bit_len - 1'b1;
              bitn <= bitn + 4'd1;
              if (bitn == 4'd0) begin
                if (rx)
                  state <= ST_IDLE;
              end else if (bitn != 4'd9) begin
                rxb <= {rx, rxb[7:1]}; // [RQ22]
              end else if (!rx) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_GAP;
                byte_idx <= byte_idx + 4'd1;
                if (byte_idx == 4'd0) begin
                  tgt <= rxb;
                  crc_acc <= crc8(crc_acc, rxb);
                end else if (byte_idx == 4'd1) begin
                  ridx <= rxb; // [RQ14]
                  crc_acc <= crc8(crc_acc, rxb);
                end else if (is_wr && didx < ndata) begin
                  dbuf[didx[2:0]] <= rxb;
                  crc_acc <= crc8(crc_acc, rxb);
                end else if (rxb != crc_acc) begin
                  state <= ST_IDLE; // [RQ16]
                  last_bad <= 1'b1;
                  last_ok <= 1'b0;
                end else begin
                  last_bad <= 1'b0;
                  last_ok <= hit;
                  link_watchdog_clear <= hit; // [RQ24]
                  wk <= 4'd0;
                  tx_crc <= `SLL_CRC_INIT;
                  if (!hit)
                    state <= ST_IDLE;
                  else if (is_wr)
                    state <= ST_WR;
                  else if (is_bc)
                    state <= ST_IDLE; // [RQ7]
                  else
                    state <= ST_TXLD; // [RQ6]
                end
              end
            end
          end
          ST_WR: begin
            if (!sw_wr) begin
              if (wr_ok(wr_addr, mem[`SLL_REG_LOCK])) // [RQ20]
                mem[wr_addr] <= dbuf[wk[2:0]]; // [RQ17]
              wk <= wk + 4'd1;
              if (wk == ndata - 4'd1) begin
                wk <= 4'd0;
                state <= is_bc ? ST_IDLE : ST_TXLD; // [RQ7]
              end
            end
          end
          ST_TXLD: begin
            tx_sh <= {1'b1, tx_cur, 1'b0}; // [RQ22]
            tx_crc <= crc8(tx_crc, tx_cur);
            cnt <= bit_len - 1'b1;
            bitn <= 4'd0;
            tx <= 1'b0;
            state <= ST_TXB;
          end
          ST_TXB: begin
            if (cnt != 0) begin
              cnt <= cnt - 1'b1;
            end else begin
              cnt <= bit_len - 1'b1;
              bitn <= bitn + 4'd1;
              tx_sh <= {1'b1, tx_sh[9:1]};
              tx <= tx_sh[1];
              if (bitn == 4'd9) begin
                tx <= 1'b1;
                wk <= wk + 4'd1;
                state <= (wk == ntx - 4'd1) ? ST_IDLE : ST_TXLD; // [RQ25]
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // running checksum over the register space
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      scan_ptr <= 8'h00;
      scan_crc <= `SLL_CRC_INIT;
      checksum <= `SLL_CRC_INIT;
    end else begin
      scan_ptr <= scan_ptr + 8'h01;
      if (scan_ptr == 8'hff) begin
        checksum <= crc8(scan_crc, mem[scan_ptr]); // [RQ21]
        scan_crc <= `SLL_CRC_INIT;
      end else begin
        scan_crc <= crc8(scan_crc, mem[scan_ptr]);
      end
    end
  end

  // ----------------------------------------
  // repurposed address pins
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      pwm_clk_out <= 1'b0;
      pwm_direct_out <= 2'b00;
    end else begin
      pwm_clk_out <= sel_int & addr_pin_2; // [RQ2]
      pwm_direct_out <= sel_int ? {addr_pin_1, addr_pin_0} : 2'b00;
    end
  end
endmodule // sll_link_slave

// *** testbench/sll_host.sv ***
`timescale 1ns/10ps
// ----
// host end of link
// ----
module sll_host #(
  parameter integer BL = 20
) (
  input wire clock,
  input wire tx,
  output logic line
);
  initial line = 1'b1;
  // start, lsb first, stop
  task automatic put(input logic [7:0] b, input bit last);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat ((i == 9 && last) ? BL / 2 : BL) @(posedge clock);
    end
  endtask
  // fresh sync per frame
  task automatic send(input logic [7:0] q[$]);
    put(8'h55, 1'b0);
    foreach (q[i]) put(q[i], i == q.size() - 1);
  endtask
  // mid-bit sampling
  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (tx !== 1'b0 && n < 3 * BL) begin
      @(posedge clock);
      n++;
    end
    ok = n < 3 * BL;
    if (ok) begin
      repeat (BL / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BL) @(posedge clock);
        b[i] = tx;
      end
      repeat (BL) @(posedge clock);
    end
  endtask
endmodule // sll_host

// *** testbench/sll_link_slave_chk.sv ***
`timescale 1ns/10ps
// ----
// port checks
// ----
module sll_link_slave_chk (
  input wire clock,
  input wire reset_n,
  input wire tx,
  input wire addr_pin_2,
  input wire addr_pin_1,
  input wire link_watchdog_clear,
  input wire pwm_clk_out,
  input wire [1:0] pwm_direct_out,
  input wire frame_busy,
  input wire sw_rd,
  input wire [7:0] sw_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rd; !sw_rd |=> sw_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd)
    else $error("read data not cleared");
  property p_pclk; $rose(pwm_clk_out) |-> $past(addr_pin_2); endproperty
  a_pclk: assert property (p_pclk)
    else $error("pwm clock not from pin");
  property p_pdir; pwm_direct_out[1] |-> $past(addr_pin_1); endproperty
  a_pdir: assert property (p_pdir)
    else $error("pwm direct not from pin");
  property p_hold; $changed(tx) |=> $stable(tx); endproperty
  a_hold: assert property (p_hold)
    else $error("tx bit too short");
  property p_txb; !tx |-> frame_busy || $past(frame_busy); endproperty
  a_txb: assert property (p_txb)
    else $error("tx active while idle");
  property p_wd1; link_watchdog_clear |=> !link_watchdog_clear; endproperty
  a_wd1: assert property (p_wd1)
    else $error("watchdog pulse too long");
  property p_wdf; link_watchdog_clear |-> $past(frame_busy); endproperty
  a_wdf: assert property (p_wdf)
    else $error("watchdog pulse outside frame");
  property p_idle;
    !frame_busy [*3] |-> tx && !link_watchdog_clear;
  endproperty
  a_idle: assert property (p_idle)
    else $error("activity while idle");
endmodule // sll_link_slave_chk
bind sll_link_slave sll_link_slave_chk i_chk (.clock(clock),
  .reset_n(reset_n), .tx(tx), .addr_pin_2(addr_pin_2),
  .addr_pin_1(addr_pin_1), .link_watchdog_clear(link_watchdog_clear),
  .pwm_clk_out(pwm_clk_out), .pwm_direct_out(pwm_direct_out),
  .frame_busy(frame_busy), .sw_rd(sw_rd), .sw_rdata(sw_rdata));

// *** testbench/sll_link_slave_tb.sv ***
`timescale 1ns/10ps
`include "sll_regs.vh"
module sll_link_slave_tb;
  localparam integer BL = 20;
  logic clock, reset_n, rx, tx, wdog, pclk, busy, sw_wr, sw_rd;
  logic [1:0] pdir;
  logic [2:0] pin;
  logic [3:0] me;
  logic [7:0] flag, sw_addr, sw_wdata, sw_rdata;
  logic [7:0] base [5] = '{8'h00, 8'h20, 8'h30, 8'h50, 8'h60};
  logic [7:0] cq[$];
  int mem [256];
  int seed = 32'h873c;
  int errors = 0;
  int num_checks = 0;
  int wdc = 0;
  // ----
  // clock, design, host
  // ----
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (wdog === 1'b1) wdc <= wdc + 1;
  sll_link_slave #(.TO_UNIT_CYC(50)) i_sll_link_slave (.clock(clock),
    .reset_n(reset_n), .rx(rx), .tx(tx), .addr_pin_2(pin[2]),
    .addr_pin_1(pin[1]), .addr_pin_0(pin[0]), .primary_flag_byte(flag),
    .link_watchdog_clear(wdog), .pwm_clk_out(pclk),
    .pwm_direct_out(pdir), .frame_busy(busy), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata));
  sll_host #(.BL(BL)) i_sll_host (.clock(clock), .tx(tx), .line(rx));
  // ----
  // model and tasks
  // ----
  function automatic bit inr(int a, int lo, int hi);
    return a >= lo && a <= hi;
  endfunction
  // lock bits guard groups
  function automatic void mwr(int a, logic [7:0] d);
    int k;
    k = mem[`SLL_REG_LOCK];
    if (!(inr(a, `SLL_CUR_LO, `SLL_CUR_HI) && k[0]) &&
        !((inr(a, `SLL_DUTY_LO, `SLL_DUTY_HI) ||
        inr(a, `SLL_LDUTY_LO, `SLL_LDUTY_HI)) && k[1]) &&
        !(inr(a, `SLL_CONF_LO, `SLL_CONF_HI) && k[2]) &&
        !(inr(a, `SLL_CLR_LO, `SLL_CLR_HI) && k[3]))
      mem[a] = d;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = `SLL_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = c[7] ? (c << 1) ^ `SLL_CRC_POLY : c << 1;
    end
    return c;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic swr(input logic [7:0] a, d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
    mwr(a, d);
    @(posedge clock);
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 chk("sw_rdata", exp, sw_rdata);
    @(posedge clock);
  endtask
  task automatic frame(input logic [7:0] tg, ix, input bit bad);
    logic [7:0] q[$];
    logic [7:0] r[$];
    logic [7:0] b;
    logic ok;
    int n, w;
    bit bc, hit;
    n = 1 << tg[5:4];
    bc = tg[6] && tg[3:0] == 4'h0;
    hit = !bad && (bc || tg[3:0] == me);
    q = {tg, ix};
    if (tg[7]) repeat (n) q.push_back(8'($random(seed)));
    q.push_back(crc8(q) ^ {7'h00, bad});
    w = wdc;
    i_sll_host.send(q);
    if (hit && tg[7])
      for (int i = 0; i < n; i++) mwr(ix + i, q[i + 2]);
    if (hit && !bc) begin
      if (!tg[7])
        for (int i = 0; i < n; i++) r.push_back(8'(mem[ix + i]));
      r.push_back(flag);
      r.push_back(crc8(r));
    end
    foreach (r[i]) begin
      i_sll_host.get(b, ok);
      chk("reply", r[i], b);
    end
    if (r.size() == 0) begin
      i_sll_host.get(b, ok);
      chk("silent", 8'h00, {7'h00, ok});
    end
    repeat (2 * BL) @(posedge clock);
    chk("wdog", {7'h00, hit}, 8'(wdc - w));
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    report_and_stop;
  end
  initial begin
    {reset_n, sw_wr, sw_rd, sw_addr, sw_wdata} <= 0;
    pin <= 3'($random(seed));
    flag <= 8'($random(seed));
    mem[`SLL_REG_LOCK] = 8'h0f;
    mem[`SLL_REG_TIMEOUT] = 8'h0f;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rdc(`SLL_REG_LOCK, 8'h0f);
    rdc(`SLL_REG_ADDRCFG, 8'h00);
    rdc(`SLL_REG_TIMEOUT, 8'h0f);
    me = {1'b0, pin};
    frame({4'h8, me}, 8'h05, 1'b0);
    rdc(8'h05, 8'h00);
    swr(`SLL_REG_ADDRCFG, {5'h01, 3'($random(seed))});
    me = {1'b1, pin};
    for (int g = 0; g < 4; g++) begin
      swr(`SLL_REG_LOCK, 8'h0f ^ (8'h01 << g));
      foreach (base[j]) swr(8'(base[j] + g), 8'($random(seed)));
      foreach (base[j]) rdc(8'(base[j] + g), 8'(mem[base[j] + g]));
    end
    $display("test locks done");
    swr(`SLL_REG_LOCK, 8'h00);
    for (int l = 0; l < 4; l++) begin
      frame({2'b10, 2'(l), me}, base[l + 1], 1'b0);
      frame({2'b00, 2'(l), me}, base[l + 1], 1'b0);
    end
    $display("test burst done");
    frame({4'h8, me}, 8'h40, 1'b1);
    rdc(`SLL_REG_LINKSTAT, 8'h02);
    frame({4'h8, me ^ 4'h1}, 8'h40, 1'b0);
    frame(8'hd0, 8'h40, 1'b0);
    frame(8'h40, 8'h40, 1'b0);
    frame({4'h5, me}, 8'h40, 1'b0);
    $display("test refusal done");
    me = 4'($random(seed));
    swr(`SLL_REG_ADDRCFG, {4'h1, me});
    @(posedge clock);
    chk("pwm_clk", {7'h00, pin[2]}, {7'h00, pclk});
    chk("pwm_dir", {6'h00, pin[1:0]}, {6'h00, pdir});
    frame({4'h9, me}, 8'h58, 1'b0);
    frame({4'h1, me}, 8'h58, 1'b0);
    i_sll_host.put(8'h55, 1'b0);
    i_sll_host.put({4'h8, me}, 1'b0);
    repeat (900) @(posedge clock);
    frame({4'h8, me}, 8'h0a, 1'b0);
    repeat (600) @(posedge clock);
    for (int i = 0; i < 256; i++) cq.push_back(8'(mem[i]));
    rdc(`SLL_REG_CHECKSUM, crc8(cq));
    rdc(`SLL_REG_LINKSTAT, 8'h01);
    $display("test address and checksum done");
    report_and_stop;
  end
endmodule // sll_link_slave_tb
